// File: mcdi_pkg.sv
// Purpose: constants for the command-complete event block
// Assumes: avalon byte addresses, one 32-bit word per register
// Notes:   slot start registers hold only the start bit
package mcdi_pkg;
  localparam int          MCDI_SLOTS       = 2;
  localparam int          MCDI_ADDR_W      = 5;
  localparam int          MCDI_DATA_W      = 32;
  localparam logic [4:0]  MCDI_OFS_RAW     = 5'h00;
  localparam logic [4:0]  MCDI_OFS_MASKED  = 5'h04;
  localparam logic [4:0]  MCDI_OFS_EN_SET  = 5'h08;
  localparam logic [4:0]  MCDI_OFS_EN_CLR  = 5'h0C;
  localparam logic [4:0]  MCDI_OFS_SLOT0   = 5'h10;
  localparam logic [4:0]  MCDI_OFS_SLOT1   = 5'h14;
  localparam int          MCDI_GO_BIT      = 31;
  localparam logic        MCDI_RST_FLAG    = 1'b0;
  localparam logic [31:0] MCDI_RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {
    MCDI_BUS_IDLE = 2'b01,
    MCDI_BUS_ACK  = 2'b10
  } mcdi_bus_type;
endpackage

// File: mcdi_slot.sv
// Purpose: one access slot: start bit, raw flag, enable, masked flag
// Assumes: done_i is a one-cycle pulse from the management engine
// Notes:   a completion in the cycle of a clear keeps the flag set
`timescale 1ns/100ps
module mcdi_slot (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic go_wr_i,
  input  wire logic done_i,
  input  wire logic raw_clr_i,
  input  wire logic msk_clr_i,
  input  wire logic en_set_i,
  input  wire logic en_clr_i,
  output logic      go_o,
  output logic      raw_o,
  output logic      en_o,
  output logic      masked_o
);
  import mcdi_pkg::*;

  logic go_reg;
  logic raw_reg;
  logic en_reg;
  logic finish;

  assign finish = go_reg & done_i;

  // ****************************************
  // start bit
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      go_reg <= MCDI_RST_FLAG;
    end else if (finish) begin
      go_reg <= 1'b0;
    end else if (go_wr_i) begin
      go_reg <= 1'b1;
    end
  end

  // ****************************************
  // raw completion flag
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      raw_reg <= MCDI_RST_FLAG;
    end else if (finish) begin
      raw_reg <= 1'b1;
    end else if (raw_clr_i || (msk_clr_i && en_reg)) begin
      raw_reg <= 1'b0;
    end
  end

  // ****************************************
  // interrupt enable
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      en_reg <= MCDI_RST_FLAG;
    end else if (en_set_i) begin
      en_reg <= 1'b1;
    end else if (en_clr_i) begin
      en_reg <= 1'b0;
    end
  end

  assign masked_o = raw_reg & en_reg;
  assign go_o     = go_reg;
  assign raw_o    = raw_reg;
  assign en_o     = en_reg;

  // ****************************************
  // checks
  // ****************************************
  a_raw_on_done: assert property (@(posedge core_clk_i) disable iff (srst_i)
    go_reg && done_i |=> raw_reg ##1 (raw_reg || $past(raw_clr_i) || $past(msk_clr_i)))
    else $error("raw flag not set by completion");
  a_raw_w1c: assert property (@(posedge core_clk_i) disable iff (srst_i)
    raw_clr_i && !finish |=> !raw_reg)
    else $error("raw flag not cleared by write one");
  a_raw_keep: assert property (@(posedge core_clk_i) disable iff (srst_i)
    raw_reg && !raw_clr_i && !msk_clr_i |=> raw_reg)
    else $error("raw flag lost without clear");
  a_masked_rise: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(masked_o) |-> $past(finish) || $past(en_set_i))
    else $error("masked flag rose without completion or enable");
  a_masked_w1c: assert property (@(posedge core_clk_i) disable iff (srst_i)
    msk_clr_i && en_reg && !finish |=> !masked_o)
    else $error("masked flag not cleared by write one");
  a_en_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
    en_set_i |=> en_reg)
    else $error("enable not set");
  a_en_off_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !en_reg |-> !masked_o)
    else $error("masked flag with enable off");
  a_en_stable: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !en_set_i && !en_clr_i |=> $stable(en_reg))
    else $error("enable changed without write one");
  a_en_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
    en_clr_i && !en_set_i |=> !en_reg)
    else $error("enable not cleared");
  a_go_selfclr: assert property (@(posedge core_clk_i) disable iff (srst_i)
    go_reg && done_i |=> !go_reg && raw_reg)
    else $error("start bit not cleared on completion");
endmodule

// File: mcdi_top.sv
// Purpose: command-complete event registers on an avalon-mm slave
// Assumes: one clock, synchronous reset, byte addressing
// Notes:   every access takes two cycles; unmapped reads return zero
`timescale 1ns/100ps
module mcdi_top (
  input  wire logic                            core_clk_i,
  input  wire logic                            srst_i,
  input  wire logic [mcdi_pkg::MCDI_ADDR_W-1:0] avs_address_i,
  input  wire logic                            avs_read_i,
  input  wire logic                            avs_write_i,
  input  wire logic [mcdi_pkg::MCDI_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                      avs_byteenable_i,
  output logic [mcdi_pkg::MCDI_DATA_W-1:0]      avs_readdata_o,
  output logic                                 avs_waitrequest_o,
  input  wire logic [mcdi_pkg::MCDI_SLOTS-1:0]  access_done_i,
  output logic [mcdi_pkg::MCDI_SLOTS-1:0]       access_start_o,
  output logic                                 cmd_done_irq_o
);
  import mcdi_pkg::*;

  mcdi_bus_type            bus_reg;
  logic [MCDI_DATA_W-1:0]  rdata_reg;
  logic                    req;
  logic                    wr_go;
  logic [MCDI_SLOTS-1:0]   lo_data;
  logic [MCDI_SLOTS-1:0]   raw;
  logic [MCDI_SLOTS-1:0]   en;
  logic [MCDI_SLOTS-1:0]   masked;
  logic [MCDI_SLOTS-1:0]   slot_go_wr;
  logic                    rd_take;

  function automatic logic hit(input logic [MCDI_ADDR_W-1:0] a, input logic [MCDI_ADDR_W-1:0] ofs);
    hit = (a[MCDI_ADDR_W-1:2] == ofs[MCDI_ADDR_W-1:2]);
  endfunction

  // ****************************************
  // avalon slave handshake
  // ****************************************
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & (bus_reg != MCDI_BUS_ACK);
  assign wr_go             = avs_write_i & (bus_reg == MCDI_BUS_ACK) & avs_byteenable_i[0];
  assign lo_data           = avs_writedata_i[MCDI_SLOTS-1:0];
  assign rd_take           = avs_read_i & (bus_reg == MCDI_BUS_IDLE);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bus_reg <= MCDI_BUS_IDLE;
    end else begin
      case (bus_reg)
        MCDI_BUS_IDLE: begin
          if (req) begin
            bus_reg <= MCDI_BUS_ACK;
          end
        end
        MCDI_BUS_ACK: begin
          bus_reg <= MCDI_BUS_IDLE;
        end
        default: begin
          bus_reg <= MCDI_BUS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_reg <= MCDI_RD_UNMAPPED;
    end else if (rd_take) begin
      rdata_reg <= MCDI_RD_UNMAPPED;
      if (hit(avs_address_i, MCDI_OFS_RAW)) begin
        rdata_reg[MCDI_SLOTS-1:0] <= raw;
      end else if (hit(avs_address_i, MCDI_OFS_MASKED)) begin
        rdata_reg[MCDI_SLOTS-1:0] <= masked;
      end else if (hit(avs_address_i, MCDI_OFS_EN_SET) || hit(avs_address_i, MCDI_OFS_EN_CLR)) begin
        rdata_reg[MCDI_SLOTS-1:0] <= en;
      end else if (hit(avs_address_i, MCDI_OFS_SLOT0)) begin
        rdata_reg[MCDI_GO_BIT] <= access_start_o[0];
      end else if (hit(avs_address_i, MCDI_OFS_SLOT1)) begin
        rdata_reg[MCDI_GO_BIT] <= access_start_o[1];
      end
    end
  end
  assign avs_readdata_o = rdata_reg;

  // ****************************************
  // slots
  // ****************************************

  for (genvar s = 0; s < MCDI_SLOTS; s++) begin : g_slot
    logic go_hit;
    assign go_hit = avs_write_i && (bus_reg == MCDI_BUS_ACK) && avs_byteenable_i[3]
                    && avs_writedata_i[MCDI_GO_BIT]
                    && hit(avs_address_i, (s == 0) ? MCDI_OFS_SLOT0 : MCDI_OFS_SLOT1);
    assign slot_go_wr[s] = go_hit;
    mcdi_slot u_slot (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .go_wr_i    (slot_go_wr[s]),
      .done_i     (access_done_i[s]),
      .raw_clr_i  (wr_go && hit(avs_address_i, MCDI_OFS_RAW) && lo_data[s]),
      .msk_clr_i  (wr_go && hit(avs_address_i, MCDI_OFS_MASKED) && lo_data[s]),
      .en_set_i   (wr_go && hit(avs_address_i, MCDI_OFS_EN_SET) && lo_data[s]),
      .en_clr_i   (wr_go && hit(avs_address_i, MCDI_OFS_EN_CLR) && lo_data[s]),
      .go_o       (access_start_o[s]),
      .raw_o      (raw[s]),
      .en_o       (en[s]),
      .masked_o   (masked[s])
    );
  end

  // ****************************************
  // interrupt output
  // ****************************************
  assign cmd_done_irq_o = |masked;

  // ****************************************
  // handshake checks
  // ****************************************
  a_wait_first: assert property (@(posedge core_clk_i) disable iff (srst_i)
    req && bus_reg == MCDI_BUS_IDLE |-> avs_waitrequest_o)
    else $error("first request cycle not stalled");

  a_wait_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !req |-> !avs_waitrequest_o)
    else $error("waitrequest without a request");

  a_wait_once: assert property (@(posedge core_clk_i) disable iff (srst_i)
    req && avs_waitrequest_o && $stable(avs_address_i) |=> !avs_waitrequest_o)
    else $error("waitrequest held more than one cycle");

  a_rd_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !rd_take |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");

  // ****************************************
  // read-back checks
  // ****************************************
  a_rd_raw: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_take && hit(avs_address_i, MCDI_OFS_RAW) |=> avs_readdata_o == MCDI_DATA_W'($past(raw)))
    else $error("raw flags read back wrong");

  a_rd_masked: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_take && hit(avs_address_i, MCDI_OFS_MASKED) |=> avs_readdata_o == MCDI_DATA_W'($past(masked)))
    else $error("masked flags read back wrong");

  a_rd_enable: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_take && (hit(avs_address_i, MCDI_OFS_EN_SET) || hit(avs_address_i, MCDI_OFS_EN_CLR))
    |=> avs_readdata_o == MCDI_DATA_W'($past(en)))
    else $error("enables read back wrong");

  a_rd_slot0: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_take && hit(avs_address_i, MCDI_OFS_SLOT0)
    |=> avs_readdata_o == {$past(access_start_o[0]), 31'h0})
    else $error("slot zero start bit read back wrong");

  a_rd_slot1: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_take && hit(avs_address_i, MCDI_OFS_SLOT1)
    |=> avs_readdata_o == {$past(access_start_o[1]), 31'h0})
    else $error("slot one start bit read back wrong");

  a_rd_unmapped: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_take && avs_address_i[MCDI_ADDR_W-1:2] > MCDI_OFS_SLOT1[MCDI_ADDR_W-1:2]
    |=> avs_readdata_o == MCDI_RD_UNMAPPED)
    else $error("unmapped read not zero");

  // ****************************************
  // write checks
  // ****************************************
  a_raw_wr_one: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_go && hit(avs_address_i, MCDI_OFS_RAW) && access_done_i == '0 |=> (raw & $past(lo_data)) == '0)
    else $error("raw write one did not clear");

  a_raw_wr_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_go && hit(avs_address_i, MCDI_OFS_RAW) |=> ((raw ^ $past(raw)) & ~$past(lo_data | access_done_i)) == '0)
    else $error("raw write zero changed a flag");

  a_msk_wr_one: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_go && hit(avs_address_i, MCDI_OFS_MASKED) && access_done_i == '0 |=> (masked & $past(lo_data)) == '0)
    else $error("masked write one did not clear");

  a_en_wr_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_go && hit(avs_address_i, MCDI_OFS_EN_SET) |=> (en & $past(lo_data)) == $past(lo_data))
    else $error("enable set write did not enable");

  a_en_wr_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_go && hit(avs_address_i, MCDI_OFS_EN_SET) |=> (en & ~$past(lo_data)) == ($past(en) & ~$past(lo_data)))
    else $error("enable set write zero changed an enable");

  a_en_wr_clr: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_go && hit(avs_address_i, MCDI_OFS_EN_CLR) |=> (en & $past(lo_data)) == '0)
    else $error("enable clear write did not disable");

  // ****************************************
  // event checks
  // ****************************************
  a_start_rise: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ((access_start_o & ~$past(access_start_o)) & ~$past(slot_go_wr)) == '0)
    else $error("start bit rose without a start write");

  a_raw_rise: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ((raw & ~$past(raw)) & ~$past(access_done_i & access_start_o)) == '0)
    else $error("raw flag rose without a completion");

  a_go_one_slot: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $onehot0(slot_go_wr))
    else $error("start write hit two slots");

  a_irq_or: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_done_irq_o == |(raw & en))
    else $error("interrupt output differs from enabled raw flags");
endmodule

// File: mcdi_top_test.sv
// Purpose: self-checking bench for the command-complete event block
// Assumes: avalon-mm master that holds each request until waitrequest is low
// Notes:   byte enables stay all ones; no random stimulus
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module mcdi_top_test;
  import mcdi_pkg::*;
  // ************************************************************
  // signals and design
  // ************************************************************
  logic        core_clk  = 1'b0;
  logic        srst      = 1'b1;
  logic [4:0]  address   = 5'h00;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitreq;
  logic [1:0]  done      = 2'h0;
  logic [1:0]  start;
  logic        irq;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  always #10 core_clk = ~core_clk;
  mcdi_top i_mcdi_top (
    .core_clk_i        (core_clk),
    .srst_i            (srst),
    .avs_address_i     (address),
    .avs_read_i        (read),
    .avs_write_i       (write),
    .avs_writedata_i   (writedata),
    .avs_byteenable_i  (4'hF),
    .avs_readdata_o    (readdata),
    .avs_waitrequest_o (waitreq),
    .access_done_i     (done),
    .access_start_o    (start),
    .cmd_done_irq_o    (irq)
  );
  // ************************************************************
  // bus and event tasks
  // ************************************************************
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitreq !== 1'b0);
    write <= 1'b0;
    `CHK(n, 2, "write wait cycles")
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e, input string m);
    int n = 0;
    @(posedge core_clk);
    address <= a;
    read    <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitreq !== 1'b0);
    `CHK(readdata, e, m)
    read <= 1'b0;
    `CHK(n, 2, "read wait cycles")
  endtask
  task automatic pulse(input logic [1:0] s);
    @(posedge core_clk);
    done <= s;
    @(posedge core_clk);
    done <= 2'h0;
    @(negedge core_clk);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk_rd(MCDI_OFS_RAW, 32'h0000_0000, "raw after reset");
    chk_rd(MCDI_OFS_MASKED, 32'h0000_0000, "masked after reset");
    chk_rd(MCDI_OFS_EN_SET, 32'h0000_0000, "enable after reset");
    chk_rd(5'h18, MCDI_RD_UNMAPPED, "unmapped read");
    `CHK(irq, 1'b0, "irq after reset")
  endtask
  task automatic t_event();
    pulse(2'h1);
    chk_rd(MCDI_OFS_RAW, 32'h0000_0000, "done without start");
    bus_wr(MCDI_OFS_SLOT0, 32'h8000_0000);
    @(negedge core_clk);
    `CHK(start, 2'h1, "start slot0")
    chk_rd(MCDI_OFS_SLOT0, 32'h8000_0000, "start readback");
    pulse(2'h1);
    `CHK(start, 2'h0, "start self clear")
    `CHK(irq, 1'b0, "irq while disabled")
    chk_rd(MCDI_OFS_RAW, 32'h0000_0001, "raw set slot0");
    chk_rd(MCDI_OFS_MASKED, 32'h0000_0000, "masked while disabled");
    bus_wr(MCDI_OFS_RAW, 32'h0000_0000);
    chk_rd(MCDI_OFS_RAW, 32'h0000_0001, "raw write zero");
    bus_wr(MCDI_OFS_RAW, 32'h0000_0001);
    chk_rd(MCDI_OFS_RAW, 32'h0000_0000, "raw write one");
  endtask
  task automatic t_enable();
    bus_wr(MCDI_OFS_EN_SET, 32'h0000_0002);
    chk_rd(MCDI_OFS_EN_SET, 32'h0000_0002, "enable set slot1");
    bus_wr(MCDI_OFS_EN_SET, 32'h0000_0000);
    chk_rd(MCDI_OFS_EN_CLR, 32'h0000_0002, "enable write zero");
    bus_wr(MCDI_OFS_SLOT1, 32'h8000_0000);
    pulse(2'h2);
    `CHK(irq, 1'b1, "irq on slot1")
    chk_rd(MCDI_OFS_MASKED, 32'h0000_0002, "masked slot1");
    bus_wr(MCDI_OFS_MASKED, 32'h0000_0000);
    chk_rd(MCDI_OFS_MASKED, 32'h0000_0002, "masked write zero");
    bus_wr(MCDI_OFS_MASKED, 32'h0000_0002);
    chk_rd(MCDI_OFS_MASKED, 32'h0000_0000, "masked write one");
    `CHK(irq, 1'b0, "irq after clear")
    bus_wr(MCDI_OFS_EN_CLR, 32'h0000_0000);
    chk_rd(MCDI_OFS_EN_SET, 32'h0000_0002, "enable clear zero");
    bus_wr(MCDI_OFS_EN_CLR, 32'h0000_0002);
    chk_rd(MCDI_OFS_EN_SET, 32'h0000_0000, "enable clear slot1");
  endtask
  task automatic t_both();
    bus_wr(MCDI_OFS_SLOT0, 32'h8000_0000);
    bus_wr(MCDI_OFS_SLOT1, 32'h8000_0000);
    pulse(2'h3);
    `CHK(irq, 1'b0, "both done disabled")
    chk_rd(MCDI_OFS_RAW, 32'h0000_0003, "raw both");
    bus_wr(MCDI_OFS_EN_SET, 32'h0000_0001);
    @(negedge core_clk);
    `CHK(irq, 1'b1, "late enable slot0")
    chk_rd(MCDI_OFS_MASKED, 32'h0000_0001, "masked slot0 only");
    bus_wr(MCDI_OFS_RAW, 32'h0000_0003);
    @(negedge core_clk);
    `CHK(irq, 1'b0, "irq after raw clear")
  endtask
  task automatic t_midreset();
    bus_wr(MCDI_OFS_EN_SET, 32'h0000_0003);
    bus_wr(MCDI_OFS_SLOT1, 32'h8000_0000);
    pulse(2'h2);
    `CHK(irq, 1'b1, "irq before reset")
    bus_wr(MCDI_OFS_SLOT0, 32'h8000_0000);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    `CHK(start, 2'h0, "start after reset")
    `CHK(irq, 1'b0, "irq after mid reset")
    chk_rd(MCDI_OFS_RAW, 32'h0000_0000, "raw after mid reset");
    chk_rd(MCDI_OFS_EN_CLR, 32'h0000_0000, "enable after mid reset");
  endtask
  // ************************************************************
  // sequence and timeout
  // ************************************************************
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_event();
    t_enable();
    t_both();
    t_midreset();
    test_done();
  end
endmodule
